//--- verilog/memory_data_slice.sv
// One memory data slice: write/read buffers, address parity, ECC check, APB registers
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Four identical slices share the data path; this module is one slice.
// - Data read from DRAM is SECDED checked; every error is logged.
// - Register writes are checked; register read data gets generated check bits.
// - Four 72-bit write entries, each eight data bytes plus eight check bits.
// - Write entries are kept separately per bank.
// - Write data stored as received; address parity folded into check bits.
// - Received write data checked and logged, never corrected.
// - Each 4-bit DRAM device holds bits of different check groups.
// - Any error on a register write aborts it, logged uncorrectable.
// - Diagnostics can invert one data bit and/or one check bit.
// - Inversion only when incoming address matches the diagnostic match address.
// - Bank 0/1 write entries selected onto DRAM bus; enable released for reads.
// - Read data buffered so DRAM cycle completes before bus is ready.
// - Four read entries, two per bank; low half quadword 0, high half 1.
// - Address parity removed from check bits before transmission.
// - Read check runs on data seen back on bus; no correction; logged.
// - Row and column parity captured per bank on load strobe.
// - Eight check bits; S3, S2 inverted; each check bit feeds own syndrome.
// - Received register write data also routed into register merge register.
// - Error register layout: bits 21,20,19,17,16 and syndromes 15:8, 7:0.
// - Transmitted quadword compared with receive latches next clock.
module memory_data_slice #(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic bus_rx_valid,
	input wire logic bus_rx_reg,
	input wire logic bus_rx_bank,
	input wire logic bus_rx_qw,
	input wire logic [63:0] bus_rx_data,
	input wire logic [7:0] bus_rx_ecc,
	input wire logic diag_addr_match,
	input wire logic load_dram_data_strobe,
	input wire logic load_bank,
	input wire logic row_parity,
	input wire logic col_parity,
	input wire logic dram_drive,
	input wire logic dram_capture,
	input wire logic dram_bank,
	input wire logic [143:0] dram_in_data,
	output logic [143:0] dram_out_data,
	output logic dram_out_oe,
	input wire logic tx_req,
	input wire logic tx_reg_req,
	input wire logic tx_bank,
	input wire logic tx_qw,
	output logic [63:0] tx_data,
	output logic [7:0] tx_ecc,
	output logic tx_valid
);
	generate
		if (ADDR_W < 4) begin : g_bad
			$error("ADDR_W must be at least 4");
		end
	endgenerate

	typedef struct packed {
		logic [3:0][71:0] wbuf;
		logic [3:0][71:0] rbuf;
		logic [1:0][1:0] par;
		logic [31:0] esr;
		logic [31:0] diag;
		logic [63:0] merge;
		logic [143:0] dram_out;
		logic dram_oe;
		logic [71:0] tx;
		logic tx_valid;
		logic tx_qw;
		logic [71:0] sent;
		logic sent_qw;
		logic chk;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} state_type;

	state_type s_r;
	state_type s_nxt;

	// Device j carries bit j and bit j+36 of both quadwords
	function automatic logic [143:0] to_dram(input logic [71:0] w0, input logic [71:0] w1);
		logic [143:0] r;
		r = '0;
		for (int j = 0; j < 36; j++) begin
			r[4*j +: 4] = {w1[j+36], w0[j+36], w1[j], w0[j]};
		end
		return r;
	endfunction

	function automatic logic [143:0] from_dram(input logic [143:0] b);
		logic [143:0] r;
		r = '0;
		for (int j = 0; j < 36; j++) begin
			r[j] = b[4*j];
			r[72+j] = b[4*j+1];
			r[j+36] = b[4*j+2];
			r[72+j+36] = b[4*j+3];
		end
		return r;
	endfunction

	logic [7:0] rx_syn;
	logic rx_single;
	logic rx_multi;
	logic [71:0] rx_word;
	logic [7:0] dflip_chk;
	logic [63:0] dflip_dat;
	logic acc;

	always_comb begin
		rx_word = {bus_rx_ecc, bus_rx_data};
		rx_syn = memory_data_pkg::ecc_syn(rx_word);
		rx_single = ^rx_syn;
		rx_multi = (rx_syn != 8'h00) && !rx_single;
		acc = psel && penable && !s_r.pready;
		dflip_dat = '0;
		dflip_chk = '0;
		// Forced corruption of the stored copy only
		if (diag_addr_match && s_r.diag[memory_data_pkg::DIAG_DEN]) begin
			dflip_dat[s_r.diag[memory_data_pkg::DIAG_DIDX_LSB +: 6]] = 1'b1;
		end
		if (diag_addr_match && s_r.diag[memory_data_pkg::DIAG_CEN]) begin
			dflip_chk[s_r.diag[memory_data_pkg::DIAG_CIDX_LSB +: 3]] = 1'b1;
		end
	end

	always_comb begin
		logic [31:0] clr;
		logic [31:0] set;
		logic [71:0] w0;
		logic [71:0] w1;
		logic [143:0] rd;
		logic [7:0] csyn;
		s_nxt = s_r;
		clr = '0;
		set = '0;
		w0 = '0;
		w1 = '0;
		rd = '0;
		csyn = '0;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;
		// APB slave, one wait state in the access phase
		if (acc) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = '0;
			case (8'(paddr))
				memory_data_pkg::OFF_ESR: begin
					s_nxt.prdata = s_r.esr;
					if (pwrite) clr = pwdata & memory_data_pkg::ESR_W1C_MASK;
				end
				memory_data_pkg::OFF_DIAG: begin
					s_nxt.prdata = s_r.diag;
					if (pwrite) s_nxt.diag = pwdata & memory_data_pkg::DIAG_MASK;
				end
				memory_data_pkg::OFF_MRG_LO: s_nxt.prdata = s_r.merge[31:0];
				memory_data_pkg::OFF_MRG_HI: s_nxt.prdata = s_r.merge[63:32];
				default: s_nxt.pslverr = 1'b1;
			endcase
		end
		// Bus reception: register writes and memory write data
		if (bus_rx_valid && bus_rx_reg) begin
			if (rx_syn != 8'h00) begin
				set[memory_data_pkg::BIT_UNC] = 1'b1;
				csyn = rx_syn;
			end else begin
				s_nxt.merge = bus_rx_data;
			end
		end else if (bus_rx_valid) begin
			// Stored as received apart from any forced diagnostic inversion, no correction
			s_nxt.wbuf[{bus_rx_bank, bus_rx_qw}] = {bus_rx_ecc ^ dflip_chk, bus_rx_data ^ dflip_dat};
			set[memory_data_pkg::BIT_CWR] = rx_single;
			set[memory_data_pkg::BIT_UNC] = rx_multi;
			csyn = rx_syn;
		end
		// Own transmission seen back in the receive latches
		if (s_r.chk) begin
			set[memory_data_pkg::BIT_TCE] = (rx_word != s_r.sent);
			set[memory_data_pkg::BIT_CRD] = rx_single;
			set[memory_data_pkg::BIT_UNC] = rx_multi;
			set[memory_data_pkg::BIT_TDE] = (rx_syn != 8'h00);
			csyn = rx_syn;
		end
		// Error register: hardware set wins over software clear
		s_nxt.esr = (s_r.esr & ~clr) | set;
		if (csyn != 8'h00) begin
			if ((s_r.chk ? s_r.sent_qw : bus_rx_qw) && !(bus_rx_reg && !s_r.chk)) begin
				s_nxt.esr[memory_data_pkg::SYN1_LSB +: 8] = csyn;
			end else begin
				s_nxt.esr[memory_data_pkg::SYN0_LSB +: 8] = csyn;
			end
		end
		if (load_dram_data_strobe) begin
			s_nxt.par[load_bank] = {row_parity, col_parity};
		end
		// Bank select onto DRAM bus with parity folded
		s_nxt.dram_oe = dram_drive;
		if (dram_drive) begin
			w0 = s_r.wbuf[{dram_bank, 1'b0}];
			w1 = s_r.wbuf[{dram_bank, 1'b1}];
			w0[71:64] = w0[71:64] ^ memory_data_pkg::par_fold(s_r.par[dram_bank]);
			w1[71:64] = w1[71:64] ^ memory_data_pkg::par_fold(s_r.par[dram_bank]);
			s_nxt.dram_out = to_dram(w0, w1);
		end
		// Read capture, independent of bus readiness
		if (dram_capture && !s_r.dram_oe) begin
			rd = from_dram(dram_in_data);
			s_nxt.rbuf[{dram_bank, 1'b0}] = rd[71:0];
			s_nxt.rbuf[{dram_bank, 1'b1}] = rd[143:72];
		end
		// Transmission: parity stripped, register data gets generated check bits
		s_nxt.tx_valid = tx_req || tx_reg_req;
		if (tx_reg_req) begin
			s_nxt.tx_qw = 1'b0;
			s_nxt.tx[63:0] = {32'h0000_0000, s_r.merge[31:0]};
			s_nxt.tx[71:64] = memory_data_pkg::ecc_calc({32'h0000_0000, s_r.merge[31:0]})
				^ memory_data_pkg::XNOR_MASK;
		end else if (tx_req) begin
			s_nxt.tx_qw = tx_qw;
			s_nxt.tx = s_r.rbuf[{tx_bank, tx_qw}];
			s_nxt.tx[71:64] = s_nxt.tx[71:64] ^ memory_data_pkg::par_fold(s_r.par[tx_bank]);
		end
		s_nxt.chk = s_r.tx_valid;
		// Quadword travels with the word itself, not with the request pins
		if (s_r.tx_valid) begin
			s_nxt.sent = s_r.tx;
			s_nxt.sent_qw = s_r.tx_qw;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.esr <= memory_data_pkg::ESR_RST;
			s_r.diag <= memory_data_pkg::DIAG_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign pready = s_r.pready;
	assign prdata = s_r.prdata;
	assign pslverr = s_r.pslverr;
	assign dram_out_data = s_r.dram_out;
	assign dram_out_oe = s_r.dram_oe;
	assign tx_data = s_r.tx[63:0];
	assign tx_ecc = s_r.tx[71:64];
	assign tx_valid = s_r.tx_valid;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	apb_wait_state_a: assert property (psel && penable && !pready |=> pready)
		else $error("APB access not answered after one wait state");
	unmapped_error_a: assert property (acc && paddr[7:0] == 8'h10 |=> pready && pslverr)
		else $error("unmapped APB offset not flagged");
	reg_abort_a: assert property (bus_rx_valid && bus_rx_reg && rx_syn != 8'h00
		|=> $stable(s_r.merge) && s_r.esr[memory_data_pkg::BIT_UNC])
		else $error("faulty register write not aborted");
	reg_merge_a: assert property (bus_rx_valid && bus_rx_reg && rx_syn == 8'h00
		|=> s_r.merge == $past(bus_rx_data))
		else $error("clean register write not merged");
	wr_single_log_a: assert property (bus_rx_valid && !bus_rx_reg && rx_single && !s_r.chk
		|=> s_r.esr[memory_data_pkg::BIT_CWR])
		else $error("single write error not logged");
	wr_store_a: assert property (bus_rx_valid && !bus_rx_reg && !diag_addr_match
		|=> s_r.wbuf[{$past(bus_rx_bank), $past(bus_rx_qw)}] == $past(rx_word))
		else $error("write entry differs from received word");
	par_capture_a: assert property (load_dram_data_strobe
		|=> s_r.par[$past(load_bank)] == {$past(row_parity), $past(col_parity)})
		else $error("bank parity not captured");
	dram_enable_a: assert property (dram_drive |=> dram_out_oe ##1 (dram_out_oe == $past(dram_drive)))
		else $error("DRAM bus enable wrong");
	tce_flag_a: assert property (tx_valid ##1 ({bus_rx_ecc, bus_rx_data} != $past(s_r.tx))
		|=> s_r.esr[memory_data_pkg::BIT_TCE])
		else $error("transmit mismatch not flagged");
	strip_parity_a: assert property (tx_req && !tx_reg_req |=> tx_valid
		&& tx_ecc == ($past(s_r.rbuf[{tx_bank, tx_qw}][71:64])
		^ memory_data_pkg::par_fold($past(s_r.par[tx_bank]))))
		else $error("parity not removed from transmitted check bits");

	read_log_a: assert property (s_r.chk && rx_single |=> s_r.esr[memory_data_pkg::BIT_CRD])
		else $error("correctable read error not logged");

	wr_multi_log_a: assert property (bus_rx_valid && !bus_rx_reg && rx_multi && !s_r.chk
		|=> s_r.esr[memory_data_pkg::BIT_UNC])
		else $error("uncorrectable write error not logged");

	wr_syn0_a: assert property (bus_rx_valid && !bus_rx_reg && rx_syn != 8'h00 && !s_r.chk
		&& !bus_rx_qw |=> s_r.esr[7:0] == $past(rx_syn))
		else $error("word 0 write syndrome not logged");

	wr_syn1_a: assert property (bus_rx_valid && !bus_rx_reg && rx_syn != 8'h00 && !s_r.chk
		&& bus_rx_qw |=> s_r.esr[15:8] == $past(rx_syn))
		else $error("word 1 write syndrome not logged");

	reg_no_cwr_a: assert property (bus_rx_valid && bus_rx_reg && !s_r.chk && !acc
		|=> s_r.esr[memory_data_pkg::BIT_CWR] == $past(s_r.esr[memory_data_pkg::BIT_CWR]))
		else $error("register write error logged as correctable");

	tde_flag_a: assert property (s_r.chk && rx_syn != 8'h00
		|=> s_r.esr[memory_data_pkg::BIT_TDE])
		else $error("transmitter during error not flagged");

	read_syn1_a: assert property (s_r.chk && rx_syn != 8'h00 && s_r.sent_qw
		|=> s_r.esr[15:8] == $past(rx_syn))
		else $error("read syndrome not logged in word 1 field");

	rbuf_capture_a: assert property (dram_capture && !s_r.dram_oe
		|=> s_r.rbuf[{$past(dram_bank), 1'b0}][0] == $past(dram_in_data[0])
		&& s_r.rbuf[{$past(dram_bank), 1'b1}][0] == $past(dram_in_data[1]))
		else $error("read entries not loaded from DRAM halves");

	dram_layout_a: assert property (dram_drive |=> dram_out_data[1:0]
		== {$past(s_r.wbuf[{dram_bank, 1'b1}][0]), $past(s_r.wbuf[{dram_bank, 1'b0}][0])})
		else $error("DRAM device bit placement wrong");

	dram_fold_a: assert property (dram_drive |=> dram_out_data[114]
		== $past(s_r.wbuf[{dram_bank, 1'b0}][64] ^ s_r.par[dram_bank][0]))
		else $error("column parity not folded into check bit 0");

	oe_idle_a: assert property (!dram_drive |=> !dram_out_oe)
		else $error("DRAM bus driven without request");

	capture_block_a: assert property (dram_capture && s_r.dram_oe
		|=> s_r.rbuf == $past(s_r.rbuf))
		else $error("read entries loaded while driving");

	tx_idle_a: assert property (!tx_req && !tx_reg_req |=> !tx_valid)
		else $error("transmit without request");

	reg_tx_ecc_a: assert property (tx_reg_req |=> tx_data[63:32] == 32'h0000_0000
		&& tx_ecc == (memory_data_pkg::ecc_calc(tx_data) ^ memory_data_pkg::XNOR_MASK))
		else $error("register read check bits wrong");

	diag_flip_a: assert property (bus_rx_valid && !bus_rx_reg && diag_addr_match
		&& s_r.diag[memory_data_pkg::DIAG_DEN] && !s_r.diag[memory_data_pkg::DIAG_CEN]
		|=> (s_r.wbuf[{$past(bus_rx_bank), $past(bus_rx_qw)}][63:0] ^ $past(bus_rx_data))
		== (64'h1 << $past(s_r.diag[5:0])))
		else $error("forced data bit inversion wrong");

	esr_clear_a: assert property (acc && pwrite && paddr[7:0] == memory_data_pkg::OFF_ESR
		&& pwdata[memory_data_pkg::BIT_CWR] && !bus_rx_valid && !s_r.chk
		|=> !s_r.esr[memory_data_pkg::BIT_CWR])
		else $error("error flag not cleared by write one");

	diag_write_a: assert property (acc && pwrite && paddr[7:0] == memory_data_pkg::OFF_DIAG
		|=> s_r.diag == ($past(pwdata) & memory_data_pkg::DIAG_MASK))
		else $error("diagnostic register write wrong");

	par_hold_a: assert property (!load_dram_data_strobe |=> s_r.par == $past(s_r.par))
		else $error("bank parity changed without strobe");

	wbuf_hold_a: assert property (!bus_rx_valid |=> s_r.wbuf == $past(s_r.wbuf))
		else $error("write entries changed without received data");

	cov_reg_abort_c: cover property (bus_rx_valid && bus_rx_reg && rx_syn != 8'h00);
	cov_reg_write_c: cover property (bus_rx_valid && bus_rx_reg ##1 tx_reg_req ##1 tx_valid);
	cov_round_trip_c: cover property (load_dram_data_strobe ##1 dram_drive ##1 dram_capture
		##1 tx_req ##2 s_r.chk);
	cov_forced_c: cover property (bus_rx_valid && diag_addr_match
		&& s_r.diag[memory_data_pkg::DIAG_DEN]);
	cov_tce_c: cover property (s_r.esr[memory_data_pkg::BIT_TCE]);
endmodule
`default_nettype wire

//--- verilog/memory_data_pkg.sv
// Constants, field layout and code helpers for the memory data slice
`default_nettype none
package memory_data_pkg;
	localparam int NUM_SLICES = 4;
	localparam int DATA_W = 64;
	localparam int CHK_W = 8;
	localparam int WORD_W = 72;
	localparam logic [7:0] OFF_ESR = 8'h00;
	localparam logic [7:0] OFF_DIAG = 8'h04;
	localparam logic [7:0] OFF_MRG_LO = 8'h08;
	localparam logic [7:0] OFF_MRG_HI = 8'h0c;
	localparam int BIT_CRD = 21;
	localparam int BIT_CWR = 20;
	localparam int BIT_UNC = 19;
	localparam int BIT_TCE = 17;
	localparam int BIT_TDE = 16;
	localparam int SYN1_LSB = 8;
	localparam int SYN0_LSB = 0;
	localparam logic [31:0] ESR_RST = 32'h0000_0000;
	localparam logic [31:0] ESR_W1C_MASK = 32'h003b_0000;
	localparam int DIAG_DIDX_LSB = 0;
	localparam int DIAG_CIDX_LSB = 8;
	localparam int DIAG_CEN = 14;
	localparam int DIAG_DEN = 15;
	localparam logic [31:0] DIAG_RST = 32'h0000_0000;
	localparam logic [31:0] DIAG_MASK = 32'h0000_c73f;
	localparam logic [7:0] XNOR_MASK = 8'h0c;
	localparam logic [7:0] ROW_PAR_MASK = 8'h10;
	localparam logic [7:0] COL_PAR_MASK = 8'h01;

	// Column of data bit idx: distinct odd-weight values of weight 3, then 5
	function automatic logic [7:0] ecc_col(input int idx);
		int n;
		logic [7:0] r;
		r = 8'h00;
		n = 0;
		for (int w = 3; w <= 5; w += 2) begin
			for (int v = 0; v < 256; v++) begin
				if ($countones(v[7:0]) == w) begin
					if (n == idx) r = v[7:0];
					n++;
				end
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] ecc_calc(input logic [63:0] d);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < DATA_W; i++) begin
			if (d[i]) s = s ^ ecc_col(i);
		end
		return s;
	endfunction

	function automatic logic [7:0] ecc_syn(input logic [71:0] w);
		return ecc_calc(w[63:0]) ^ w[71:64] ^ XNOR_MASK;
	endfunction

	function automatic logic [7:0] par_fold(input logic [1:0] p);
		return (p[1] ? ROW_PAR_MASK : 8'h00) ^ (p[0] ? COL_PAR_MASK : 8'h00);
	endfunction
endpackage
`default_nettype wire

//--- tb/far_side_model.sv
// Far-side model: system bus receive latches with transmit echo, and a DRAM array
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic rx_go,
	input wire logic rx_reg,
	input wire logic rx_bank,
	input wire logic rx_qw,
	input wire logic [63:0] rx_data,
	input wire logic [7:0] rx_ecc,
	input wire logic bad_echo,
	input wire logic [63:0] tx_data,
	input wire logic [7:0] tx_ecc,
	input wire logic tx_valid,
	input wire logic [143:0] dram_out_data,
	input wire logic dram_out_oe,
	output logic bus_rx_valid,
	output logic bus_rx_reg,
	output logic bus_rx_bank,
	output logic bus_rx_qw,
	output logic [63:0] bus_rx_data,
	output logic [7:0] bus_rx_ecc,
	output logic [143:0] dram_in_data
);
	logic [143:0] cells_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{bus_rx_valid, bus_rx_reg, bus_rx_bank, bus_rx_qw} <= 4'h0;
			bus_rx_data <= 64'h0;
			bus_rx_ecc <= 8'h0;
			cells_r <= 144'h0;
		end else begin
			bus_rx_valid <= rx_go;
			bus_rx_reg <= rx_reg;
			bus_rx_bank <= rx_bank;
			bus_rx_qw <= rx_qw;
			if (tx_valid) begin
				// Own word shows up one tick later, optionally damaged on the wire
				bus_rx_data <= tx_data ^ {63'h0, bad_echo};
				bus_rx_ecc <= tx_ecc;
			end else if (rx_go) begin
				bus_rx_data <= rx_data;
				bus_rx_ecc <= rx_ecc;
			end else begin
				// Idle bus: nothing valid is left standing
				bus_rx_data <= ~bus_rx_data;
				bus_rx_ecc <= ~bus_rx_ecc;
			end
			if (dram_out_oe) begin
				cells_r <= dram_out_data;
			end
		end
	end
	assign dram_in_data = dram_out_oe ? dram_out_data : cells_r;
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking testbench for one memory data slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dram_out_oe, tx_valid, serr;
	logic [7:0] paddr, tx_ecc, rx_ecc, bus_rx_ecc, se;
	logic [31:0] pwdata, prdata, rd;
	logic [63:0] tx_data, rx_data, bus_rx_data, sd;
	logic [143:0] dram_in_data, dram_out_data;
	logic rx_go, rx_reg, rx_bank, rx_qw, bad_echo, bus_rx_valid, bus_rx_reg, bus_rx_bank, bus_rx_qw;
	logic match, ld, load_bank, row_parity, col_parity, dram_drive, dram_capture, dram_bank;
	logic tx_req, tx_reg_req, tx_bank, tx_qw;
	int err_total, checks_done;
	memory_data_slice i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .bus_rx_valid(bus_rx_valid), .bus_rx_reg(bus_rx_reg),
		.bus_rx_bank(bus_rx_bank), .bus_rx_qw(bus_rx_qw), .bus_rx_data(bus_rx_data),
		.bus_rx_ecc(bus_rx_ecc), .diag_addr_match(match), .load_dram_data_strobe(ld),
		.load_bank(load_bank), .row_parity(row_parity), .col_parity(col_parity),
		.dram_drive(dram_drive), .dram_capture(dram_capture), .dram_bank(dram_bank),
		.dram_in_data(dram_in_data), .dram_out_data(dram_out_data), .dram_out_oe(dram_out_oe),
		.tx_req(tx_req), .tx_reg_req(tx_reg_req), .tx_bank(tx_bank), .tx_qw(tx_qw),
		.tx_data(tx_data), .tx_ecc(tx_ecc), .tx_valid(tx_valid));
	far_side_model i_far (.pclk(pclk), .presetn(presetn), .rx_go(rx_go), .rx_reg(rx_reg),
		.rx_bank(rx_bank), .rx_qw(rx_qw), .rx_data(rx_data), .rx_ecc(rx_ecc),
		.bad_echo(bad_echo), .tx_data(tx_data), .tx_ecc(tx_ecc), .tx_valid(tx_valid),
		.dram_out_data(dram_out_data), .dram_out_oe(dram_out_oe), .bus_rx_valid(bus_rx_valid),
		.bus_rx_reg(bus_rx_reg), .bus_rx_bank(bus_rx_bank), .bus_rx_qw(bus_rx_qw),
		.bus_rx_data(bus_rx_data), .bus_rx_ecc(bus_rx_ecc), .dram_in_data(dram_in_data));
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk(pready, 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rx(input logic r, b, q, input logic [63:0] d, input logic [7:0] e);
		@(posedge pclk);
		{rx_go, rx_reg, rx_bank, rx_qw, rx_data, rx_ecc} <= {1'b1, r, b, q, d, e};
		@(posedge pclk);
		rx_go <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask
	task automatic par(input logic b, rp, cp);
		@(posedge pclk);
		{ld, load_bank, row_parity, col_parity} <= {1'b1, b, rp, cp};
		@(posedge pclk);
		ld <= 1'b0;
	endtask
	task automatic dram_cycle(input logic b);
		@(posedge pclk);
		{dram_drive, dram_bank} <= {1'b1, b};
		@(posedge pclk);
		dram_drive <= 1'b0;
		#1 chk(dram_out_oe, 1);
		@(posedge pclk);
		#1 chk(dram_out_oe, 0);
		@(posedge pclk);
		dram_capture <= 1'b1;
		@(posedge pclk);
		dram_capture <= 1'b0;
	endtask
	task automatic send(input logic r, b, q);
		@(posedge pclk);
		{tx_req, tx_reg_req, tx_bank, tx_qw} <= {~r, r, b, q};
		@(posedge pclk);
		{tx_req, tx_reg_req, tx_bank, tx_qw} <= 4'h0;
		#1 chk(tx_valid, 1);
		sd = tx_data;
		se = tx_ecc;
		repeat (4) @(posedge pclk);
	endtask
	task automatic esr_is(input logic [31:0] mask, input logic [31:0] exp);
		apb(0, memory_data_pkg::OFF_ESR, 0);
		chk(rd & mask, exp);
	endtask
	task automatic t_regs;
		esr_is(32'hffffffff, 0);
		apb(1, memory_data_pkg::OFF_DIAG, 32'hffffffff);
		apb(0, memory_data_pkg::OFF_DIAG, 0);
		chk(rd, 32'h0000c73f);
		apb(1, memory_data_pkg::OFF_DIAG, 0);
		apb(0, 8'h10, 0);
		chk({serr, rd}, {1'b1, 32'h0});
		$display("test regs done");
	endtask
	task automatic t_round_trip;
		rx(0, 0, 0, 64'h1, 8'h0c);
		esr_is(32'h003b00ff, 32'h00100007);
		rx(0, 0, 1, 64'h2, 8'h07);
		par(0, 1, 1);
		dram_cycle(0);
		par(0, 0, 1);
		par(1, 1, 1);
		apb(1, memory_data_pkg::OFF_ESR, 32'h003b0000);
		send(0, 0, 1);
		chk({sd, se}, {64'h2, 8'h17});
		esr_is(32'h003bff00, 32'h00211000);
		send(0, 0, 0);
		chk(sd, 64'h1);
		$display("test round trip done");
	endtask
	task automatic t_tx_check;
		apb(1, memory_data_pkg::OFF_ESR, 32'h003b0000);
		bad_echo <= 1'b1;
		send(0, 0, 1);
		bad_echo <= 1'b0;
		esr_is(32'h00020000, 32'h00020000);
		$display("test transmit check done");
	endtask
	task automatic t_reg_write;
		apb(1, memory_data_pkg::OFF_ESR, 32'h003b0000);
		rx(1, 0, 0, 64'h1, 8'h0b);
		apb(0, memory_data_pkg::OFF_MRG_LO, 0);
		chk(rd, 32'h1);
		rx(1, 0, 0, 64'h2, 8'h0b);
		apb(0, memory_data_pkg::OFF_MRG_LO, 0);
		chk(rd, 32'h1);
		esr_is(32'h00180000, 32'h00080000);
		send(1, 0, 0);
		chk({sd, se}, {64'h1, 8'h0b});
		$display("test register write done");
	endtask
	task automatic t_diag;
		apb(1, memory_data_pkg::OFF_DIAG, 32'h00008000);
		for (int k = 0; k < 2; k++) begin
			match <= k[0];
			rx(0, 1, 0, 64'h0, 8'h0c);
			par(1, 0, 0);
			dram_cycle(1);
			send(0, 1, 0);
			chk(sd, {63'h0, k[0]});
		end
		$display("test diagnostic flip done");
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		#100000;
		err_total++;
		report_and_stop();
	end
	initial begin
		err_total = 0;
		checks_done = 0;
		{presetn, psel, penable, pwrite, paddr, pwdata, rx_go, rx_reg, rx_bank, rx_qw} = '0;
		{rx_data, rx_ecc, bad_echo, match, ld, load_bank, row_parity, col_parity} = '0;
		{dram_drive, dram_capture, dram_bank, tx_req, tx_reg_req, tx_bank, tx_qw} = '0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_round_trip();
		t_tx_check();
		t_reg_write();
		t_diag();
		report_and_stop();
	end
endmodule
`default_nettype wire
